/* File: src/wdt_pkg.sv */
// Package for the watchdog block: register map, field layout, counts.
// Assumes a 32-bit APB slave; the control register sits in the low byte.
package wdt_pkg;
    localparam logic [7:0] CTRL_OFFSET = 8'h38;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int RUN_BIT = 3;
    localparam int SEL_BIT = 2;
    localparam int TEST_MSB = 1;
    localparam logic [4:0] LIMIT_SHORT = 5'h04;
    localparam logic [4:0] LIMIT_LONG = 5'h10;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [1:0] EDGE_RESET = 2'h0;
endpackage

/* File: src/tick_edge.sv */
// Rising-edge detector for the 2 Hz tick from the base timer.
// Assumes the tick input is already synchronous to the clock.
`timescale 1ns/10ps
module tick_edge (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic tick_in,
    output logic pulse_out
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.prev = tick_in;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // One pulse per tick period, so each count is half a second
    assign pulse_out = tick_in & ~state.prev;
endmodule

/* File: src/watchdog_timer.sv */
// Watchdog timer with one control register on an APB slave port.
// Assumes a 2 Hz tick level from the base timer, synchronous to CLK_IN.
//
// Overview of operation
// - Watchdog runs only while run flag set
// - Select bit zero: 8 s, one: 2 s
// - Count advances once per 2 Hz tick
// - Count 4 or 16 raises system reset
// - Any control write clears the count
// - System reset clears the run flag
`timescale 1ns/10ps
module watchdog_timer (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Base timer tick
    input wire logic TICK_2HZ_IN,
    // Watchdog reset request, one cycle wide
    output logic WDT_RESET_OUT
);
    typedef struct packed {
        logic run;
        logic sel;
        logic [1:0] test;
        logic [4:0] count;
        logic [31:0] rdata;
        logic err;
        logic fire;
    } wdt_state_t;

    wdt_state_t state;
    wdt_state_t next_state;
    logic tick;
    logic access;
    logic hit;
    logic [4:0] limit;

    tick_edge u_tick (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .tick_in(TICK_2HZ_IN),
        .pulse_out(tick)
    );

    // Zero-wait slave: every access completes in its first access cycle
    assign access = PSEL_IN & PENABLE_IN;
    assign hit = (PADDR_IN[7:0] == wdt_pkg::CTRL_OFFSET) && (PADDR_IN[31:8] == 24'h00_0000);
    assign limit = state.sel ? wdt_pkg::LIMIT_SHORT : wdt_pkg::LIMIT_LONG;

    always_comb begin
        next_state = state;
        next_state.fire = 1'b0;
        next_state.err = 1'b0;
        if (!state.run) begin
            next_state.count = wdt_pkg::COUNT_RESET;
        end else if (tick) begin
            next_state.count = state.count + 5'h01;
        end
        if (state.run && state.count >= limit) begin
            next_state.fire = 1'b1;
            next_state.count = wdt_pkg::COUNT_RESET;
        end
        if (access) begin
            next_state.err = ~hit;
            if (PWRITE_IN && hit) begin
                next_state.count = wdt_pkg::COUNT_RESET;
                if (PSTRB_IN[0]) begin
                    next_state.run = PWDATA_IN[wdt_pkg::RUN_BIT];
                    next_state.sel = PWDATA_IN[wdt_pkg::SEL_BIT];
                    next_state.test = PWDATA_IN[wdt_pkg::TEST_MSB:0];
                end
            end
        end
        // Read data captured at setup so it is stable in the access cycle
        next_state.rdata = '0;
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && hit) begin
            next_state.rdata[wdt_pkg::RUN_BIT] = state.run;
            next_state.rdata[wdt_pkg::SEL_BIT] = state.sel;
            next_state.rdata[wdt_pkg::TEST_MSB:0] = state.test;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign PRDATA_OUT = state.rdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access & ~hit;
    assign WDT_RESET_OUT = state.fire;
endmodule

/* File: testbench/wdt_sva.sv */
// Checker on watchdog_timer ports.
// Assumes every write carries byte lane 0.
`timescale 1ns/10ps
module wdt_sva (
    input wire logic CLK_IN, RESETN_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
    input wire logic TICK_2HZ_IN, WDT_RESET_OUT,
    input wire logic [31:0] PADDR_IN, PWDATA_IN, PRDATA_OUT
);
    logic run, sel;
    wire a = PSEL_IN & PENABLE_IN & (PADDR_IN == 32'h38);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
        if (!RESETN_IN) {run, sel} <= 2'h0;
        else if (a & PWRITE_IN) {run, sel} <= PWDATA_IN[3:2];
    AST_OFF: assert property (!run |-> !WDT_RESET_OUT) else $error("off");
    AST_RD: assert property (a & !PWRITE_IN |-> PRDATA_OUT[3:2] == {run, sel})
        else $error("rd");
    AST_ONE: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT) else $error("one");
    AST_CLR: assert property (a & PWRITE_IN |=> !WDT_RESET_OUT [*2]) else $error("clr");
    AST_TICK: assert property (WDT_RESET_OUT |-> $past(TICK_2HZ_IN, 2)) else $error("tk");
    // At least four tick edges, two cycles apart, lie between two requests
    AST_GAP: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT [*6])
        else $error("gap");
endmodule
bind watchdog_timer wdt_sva sva_u (.*);

/* File: testbench/tb.sv */
// Bench for watchdog_timer: APB master, 2 Hz ticks made here.
`timescale 1ns/10ps
module tb;
    logic CLK_IN = 0, RESETN_IN = 0, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
    logic TICK_2HZ_IN = 0, WDT_RESET_OUT, PREADY_OUT, PSLVERR_OUT;
    logic [31:0] PADDR_IN = 0, PWDATA_IN = 0, PRDATA_OUT;
    int num_errors = 0, cmp_count = 0, hits, i;
    watchdog_timer dut_u (.*, .PSTRB_IN(4'h1));
    initial forever #12.5 CLK_IN = ~CLK_IN;
    task chk(input logic [31:0] g, e);
        cmp_count++;
        num_errors += int'(g !== e);
        if (g !== e) $display("ERROR %0t %h %h", $time, g, e);
    endtask
    task apb(input logic wr, input logic [31:0] d, input logic [31:0] a = 32'h38);
        {PSEL_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= {1'b1, wr, a, d};
        @(posedge CLK_IN) PENABLE_IN <= 1;
        for (i = 0; i < 9; i++) @(posedge CLK_IN) if (PREADY_OUT === 1'b1) break;
        if (i == 9) finish_test(1);
        chk(PSLVERR_OUT, a != 32'h38);
        if (!wr) chk(PRDATA_OUT, d);
        {PSEL_IN, PENABLE_IN} <= 2'h0;
        @(posedge CLK_IN);
    endtask
    // Tick high three cycles, low five: one count per tick
    task tk(input int n, e);
        hits = 0;
        for (i = 0; i < n * 8; i++) begin
            @(posedge CLK_IN);
            hits += int'(WDT_RESET_OUT === 1'b1);
            TICK_2HZ_IN <= i % 8 < 3;
        end
        chk(hits, e);
    endtask
    task t_reg;
        apb(0, 32'h0);
        apb(1, 32'h4);
        apb(0, 32'h4);
        apb(0, 32'h0, 32'h3C);
        tk(20, 0);
        $display("t_reg end");
    endtask
    task t_run;
        apb(1, 32'hC);
        tk(3, 0);
        apb(1, 32'h0, 32'h3C);
        tk(1, 1);
        apb(1, 32'h8);
        tk(15, 0);
        apb(1, 32'h8);
        tk(15, 0);
        tk(1, 1);
        $display("t_run end");
    endtask
    task t_rst;
        apb(1, 32'hC);
        RESETN_IN <= 0;
        repeat (2) @(posedge CLK_IN);
        RESETN_IN <= 1;
        apb(0, 32'h0);
        tk(6, 0);
        $display("t_rst end");
    endtask
    task finish_test(input int t);
        num_errors += t;
        $display("errors %0d checks %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge CLK_IN);
        RESETN_IN <= 1;
        t_reg;
        t_run;
        t_rst;
        finish_test(0);
    end
endmodule
